// ---- esq_pkg.sv ----
`default_nettype none
package esq_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ESQ_ADDR_MEAS   = 8'h00;
    localparam logic [7:0] ESQ_ADDR_HUM    = 8'h04;
    localparam logic [7:0] ESQ_ADDR_GAS    = 8'h08;
    localparam logic [7:0] ESQ_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ESQ_ADDR_PROF   = 8'h40;
    localparam logic [7:0] ESQ_ADDR_PROF_END = 8'h68;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int ESQ_MODE_LSB   = 0;
    localparam int ESQ_OSRS_T_LSB = 2;
    localparam int ESQ_OSRS_P_LSB = 5;
    localparam int ESQ_OSRS_H_LSB = 0;
    localparam int ESQ_SEL_LSB    = 0;
    localparam int ESQ_GAS_EN_BIT = 4;
    localparam int ESQ_SETPT_LSB  = 0;
    localparam int ESQ_DUR_LSB    = 8;
    localparam int ESQ_ST_BUSY    = 0;
    localparam int ESQ_ST_PEND    = 1;
    localparam int ESQ_ST_HEAT    = 2;
    localparam int ESQ_ST_PHASE   = 4;

    // ---------------------------------------------------------------
    // Encodings and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] ESQ_MODE_SLEEP  = 2'h0;
    localparam logic [1:0] ESQ_MODE_FORCED = 2'h1;
    localparam logic [2:0] ESQ_OSRS_MAX    = 3'h5;
    localparam logic [2:0] ESQ_OSRS_RST    = 3'h0;
    localparam logic [3:0] ESQ_SEL_RST     = 4'h0;
    localparam logic [1:0] ESQ_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ESQ_RESP_SLVERR = 2'h2;
    localparam int         ESQ_NUM_PROFILES = 10;
    localparam int         ESQ_PROF_W       = 16;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int ESQ_CLK_PERIOD_NS  = 10;
    localparam int ESQ_CONV_TIME_NS   = 2000;
    localparam int ESQ_GAS_TIME_NS    = 2000;
    localparam int ESQ_HEAT_UNIT_NS   = 1000000;
    localparam int ESQ_CONV_CYCLES    = (ESQ_CONV_TIME_NS + ESQ_CLK_PERIOD_NS - 1) / ESQ_CLK_PERIOD_NS;
    localparam int ESQ_GAS_CYCLES     = (ESQ_GAS_TIME_NS + ESQ_CLK_PERIOD_NS - 1) / ESQ_CLK_PERIOD_NS;
    localparam int ESQ_HEAT_UNIT_DFLT = (ESQ_HEAT_UNIT_NS + ESQ_CLK_PERIOD_NS - 1) / ESQ_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ESQ_SLEEP, ESQ_TEMP, ESQ_PRES, ESQ_HUM, ESQ_HEAT, ESQ_GAS
    } esq_state_t;
endpackage
`default_nettype wire

// ---- esq_prof_if.sv ----
`default_nettype none
interface esq_prof_if;
    import esq_pkg::*;
    logic                  wr_en;
    logic [3:0]            wr_idx;
    logic [ESQ_PROF_W-1:0] wr_data;
    logic [3:0]            idx_a;
    logic [ESQ_PROF_W-1:0] rd_a;
    logic [3:0]            idx_b;
    logic [ESQ_PROF_W-1:0] rd_b;
    modport mem (input wr_en, wr_idx, wr_data, idx_a, idx_b, output rd_a, rd_b);
    modport ctl (output wr_en, wr_idx, wr_data, idx_a, idx_b, input rd_a, rd_b);
endinterface
`default_nettype wire

// ---- esq_profile_mem.sv ----
`default_nettype none
module esq_profile_mem
    import esq_pkg::*;
#(
    parameter int DEPTH = ESQ_NUM_PROFILES
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Profile port
    esq_prof_if.mem   prof
);
    import esq_pkg::*;

    logic [ESQ_PROF_W-1:0] entry [DEPTH];

    if (DEPTH < 1 || DEPTH > 16)
    begin : g_chk
        $error("Profile depth must be 1 to 16");
    end

    // ---------------------------------------------------------------
    // Storage, one register per profile
    // ---------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge core_clk)
        begin
            if (srst)
                entry[i] <= '0;
            else if (prof.wr_en && prof.wr_idx == 4'(i))
                entry[i] <= prof.wr_data;
        end
    end

    // Registered reads; out-of-range index reads zero
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prof.rd_a <= '0;
            prof.rd_b <= '0;
        end
        else
        begin
            prof.rd_a <= (int'(prof.idx_a) < DEPTH) ? entry[prof.idx_a] : '0;
            prof.rd_b <= (int'(prof.idx_b) < DEPTH) ? entry[prof.idx_b] : '0;
        end
    end
endmodule
`default_nettype wire

// ---- esq_mode_sequencer.sv ----
`default_nettype none
// Overview of operation
// - Reset leaves sequencer asleep, mode sleep
// - Mode 00: no conversions, heater off
// - Mode 01 runs one full measurement cycle
// - Cycle end returns to sleep unaided
// - Heater powered only during gas phase
// - Mode write during cycle waits for end
// - While change pending, control writes dropped
// - Order: temperature, pressure, humidity, gas
// - Ten stored setpoint and duration profiles
// - Four-bit field selects heater profile
// - Gas phase runs only with enable set
// - Oversampling zero skips that conversion
module esq_mode_sequencer
    import esq_pkg::*;
#(
    parameter int unsigned HEAT_UNIT_CYCLES = ESQ_HEAT_UNIT_DFLT
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Measurement front end
    output var  logic        conv_active,
    output var  logic        heater_on,
    output var  logic [7:0]  heater_setpoint,
    output var  logic        cycle_done
);
    import esq_pkg::*;

    if (HEAT_UNIT_CYCLES < 1 || HEAT_UNIT_CYCLES > 16777215)
    begin : g_chk
        $error("HEAT_UNIT_CYCLES out of range");
    end

    esq_prof_if prof ();
    esq_profile_mem #(.DEPTH(ESQ_NUM_PROFILES)) u_mem (.core_clk(core_clk), .srst(srst), .prof(prof));

    esq_state_t  state;
    esq_state_t  next_state;
    logic [1:0]  mode;
    logic [1:0]  pend_mode;
    logic        pend;
    logic [2:0]  osrs_t, osrs_p, osrs_h;
    logic [3:0]  heater_profile_select;
    logic        gas_en;
    logic [2:0]  run_t, run_p, run_h;
    logic        run_gas;
    logic [3:0]  run_sel;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        start;
    logic        busy;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_full, w_full, wr_go, rd_stage;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;
    logic        prof_hit_w, prof_hit_r;

    assign busy  = (state != ESQ_SLEEP);
    assign start = (state == ESQ_SLEEP) && (mode == ESQ_MODE_FORCED);
    assign wr_go = aw_full && w_full && !s_axi_bvalid;
    assign prof_hit_w = (aw_addr >= ESQ_ADDR_PROF) && (aw_addr < ESQ_ADDR_PROF_END) && (aw_addr[1:0] == 2'h0);
    assign prof_hit_r = (ar_addr >= ESQ_ADDR_PROF) && (ar_addr < ESQ_ADDR_PROF_END) && (ar_addr[1:0] == 2'h0);

    // ---------------------------------------------------------------
    // Phase order helpers
    // ---------------------------------------------------------------
    function automatic esq_state_t first_after(input esq_state_t s, input logic [3:0] en);
        logic [3:0] m;
        m = 4'h0;
        case (s)
            ESQ_SLEEP: m = en & 4'hf;
            ESQ_TEMP:  m = en & 4'he;
            ESQ_PRES:  m = en & 4'hc;
            ESQ_HUM:   m = en & 4'h8;
            default:   m = 4'h0;
        endcase
        if (m[0])
            first_after = ESQ_TEMP;
        else if (m[1])
            first_after = ESQ_PRES;
        else if (m[2])
            first_after = ESQ_HUM;
        else if (m[3])
            first_after = ESQ_HEAT;
        else
            first_after = ESQ_SLEEP;
    endfunction

    function automatic logic [31:0] conv_len(input logic [2:0] o);
        logic [2:0] c;
        c = (o > ESQ_OSRS_MAX) ? ESQ_OSRS_MAX : o;
        conv_len = (32'(ESQ_CONV_CYCLES) << (c - 3'h1)) - 32'h1;
    endfunction

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt != 32'h0) ? cnt - 32'h1 : cnt;
        if (start)
            next_state = first_after(ESQ_SLEEP, {gas_en, |osrs_h, |osrs_p, |osrs_t});
        else if (busy && cnt == 32'h0)
        begin
            if (state == ESQ_HEAT)
                next_state = ESQ_GAS;
            else
                next_state = first_after(state, {run_gas, |run_h, |run_p, |run_t});
        end
        if (next_state != state || start)
        begin
            case (next_state)
                ESQ_TEMP: next_cnt = conv_len(start ? osrs_t : run_t);
                ESQ_PRES: next_cnt = conv_len(start ? osrs_p : run_p);
                ESQ_HUM:  next_cnt = conv_len(start ? osrs_h : run_h);
                ESQ_HEAT: next_cnt = 32'(prof.rd_a[ESQ_DUR_LSB +: 8]) * 32'(HEAT_UNIT_CYCLES);
                ESQ_GAS:  next_cnt = 32'(ESQ_GAS_CYCLES - 1);
                default:  next_cnt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state <= ESQ_SLEEP;
            cnt   <= 32'h0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Settings are frozen for the whole cycle so that writes between phases cannot reorder it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            run_t   <= ESQ_OSRS_RST;
            run_p   <= ESQ_OSRS_RST;
            run_h   <= ESQ_OSRS_RST;
            run_gas <= 1'b0;
            run_sel <= ESQ_SEL_RST;
        end
        else if (start)
        begin
            run_t   <= osrs_t;
            run_p   <= osrs_p;
            run_h   <= osrs_h;
            run_gas <= gas_en;
            run_sel <= heater_profile_select;
        end
    end

    // Front-end outputs follow the next state so they line up with it exactly
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            conv_active     <= 1'b0;
            heater_on       <= 1'b0;
            heater_setpoint <= 8'h0;
            cycle_done      <= 1'b0;
        end
        else
        begin
            conv_active <= (next_state != ESQ_SLEEP);
            heater_on   <= (next_state == ESQ_HEAT) || (next_state == ESQ_GAS);
            if (next_state == ESQ_HEAT && state != ESQ_HEAT)
                heater_setpoint <= prof.rd_a[ESQ_SETPT_LSB +: 8];
            cycle_done  <= (busy || start) && next_state == ESQ_SLEEP;
        end
    end

    // In sleep the live field feeds the memory, so the data are ready when a cycle starts
    assign prof.idx_a   = busy ? run_sel : heater_profile_select;
    // Index follows the address as it is taken, so the registered word is fresh one edge later
    assign prof.idx_b   = 4'((((s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_addr) - ESQ_ADDR_PROF) >> 2);
    assign prof.wr_idx  = 4'((aw_addr - ESQ_ADDR_PROF) >> 2);
    assign prof.wr_data = w_data[ESQ_PROF_W-1:0];
    assign prof.wr_en   = wr_go && !pend && prof_hit_w && (&w_strb[1:0]);

    // ---------------------------------------------------------------
    // Control registers and mode handling
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mode      <= ESQ_MODE_SLEEP;
            pend      <= 1'b0;
            pend_mode <= ESQ_MODE_SLEEP;
            osrs_t    <= ESQ_OSRS_RST;
            osrs_p    <= ESQ_OSRS_RST;
            osrs_h    <= ESQ_OSRS_RST;
            gas_en    <= 1'b0;
            heater_profile_select <= ESQ_SEL_RST;
        end
        else
        begin
            if (busy && next_state == ESQ_SLEEP)
            begin
                mode <= pend ? pend_mode : ESQ_MODE_SLEEP;
                pend <= 1'b0;
            end
            // A change taken in the last busy cycle lands here, one cycle after the end
            else if (pend && !busy)
            begin
                mode <= pend_mode;
                pend <= 1'b0;
            end
            else if (start && next_state == ESQ_SLEEP)
                mode <= ESQ_MODE_SLEEP;
            if (wr_go && !pend && w_strb[0])
            begin
                if (aw_addr == ESQ_ADDR_MEAS)
                begin
                    osrs_t <= w_data[ESQ_OSRS_T_LSB +: 3];
                    osrs_p <= w_data[ESQ_OSRS_P_LSB +: 3];
                    if (busy)
                    begin
                        pend      <= 1'b1;
                        pend_mode <= w_data[ESQ_MODE_LSB +: 2];
                    end
                    else if (!start)
                        mode <= w_data[ESQ_MODE_LSB +: 2];
                end
                else if (aw_addr == ESQ_ADDR_HUM)
                    osrs_h <= w_data[ESQ_OSRS_H_LSB +: 3];
                else if (aw_addr == ESQ_ADDR_GAS)
                begin
                    heater_profile_select <= w_data[ESQ_SEL_LSB +: 4];
                    gas_en                <= w_data[ESQ_GAS_EN_BIT];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 8'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ESQ_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ESQ_ADDR_MEAS || aw_addr == ESQ_ADDR_HUM || aw_addr == ESQ_ADDR_GAS
                                 || aw_addr == ESQ_ADDR_STATUS || prof_hit_w) ? ESQ_RESP_OKAY : ESQ_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    always_comb
    begin
        rd_word = 32'h0;
        rd_resp = ESQ_RESP_OKAY;
        if (ar_addr == ESQ_ADDR_MEAS)
            rd_word = 32'({osrs_p, osrs_t, mode});
        else if (ar_addr == ESQ_ADDR_HUM)
            rd_word = 32'(osrs_h);
        else if (ar_addr == ESQ_ADDR_GAS)
            rd_word = 32'({gas_en, heater_profile_select});
        else if (ar_addr == ESQ_ADDR_STATUS)
            rd_word = 32'({state, 1'b0, heater_on, pend, busy});
        else if (prof_hit_r)
            rd_word = 32'(prof.rd_b);
        else
            rd_resp = ESQ_RESP_SLVERR;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ar_addr       <= 8'h0;
            rd_stage      <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= ESQ_RESP_OKAY;
        end
        else
        begin
            rd_stage <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_addr       <= s_axi_araddr;
                rd_stage      <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            else if (!s_axi_rvalid && !rd_stage)
                s_axi_arready <= 1'b1;
            // One spare cycle lets the profile memory present its registered word
            if (rd_stage)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_resp;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_cycle_end;
        busy && !pend ##1 !busy;
    endsequence

    property p_reset_sleep;
        @(posedge core_clk) disable iff (srst) $fell(srst) |-> state == ESQ_SLEEP && mode == ESQ_MODE_SLEEP;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep) else $error("not asleep after reset");

    property p_sleep_quiet;
        @(posedge core_clk) disable iff (srst) state == ESQ_SLEEP |-> !conv_active && !heater_on;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

    property p_start;
        @(posedge core_clk) disable iff (srst)
            start && (|osrs_t) |=> state == ESQ_TEMP && conv_active;
    endproperty
    a_start: assert property (p_start) else $error("forced mode did not start");

    property p_auto_sleep;
        @(posedge core_clk) disable iff (srst) s_cycle_end |-> mode == ESQ_MODE_SLEEP;
    endproperty
    a_auto_sleep: assert property (p_auto_sleep) else $error("mode not back to sleep");

    property p_heater;
        @(posedge core_clk) disable iff (srst) heater_on == (state == ESQ_HEAT || state == ESQ_GAS);
    endproperty
    a_heater: assert property (p_heater) else $error("heater outside gas phase");

    property p_defer;
        @(posedge core_clk) disable iff (srst)
            wr_go && !pend && w_strb[0] && busy && next_state != ESQ_SLEEP && aw_addr == ESQ_ADDR_MEAS
            |=> pend && $stable(mode);
    endproperty
    a_defer: assert property (p_defer) else $error("mode change not deferred");

    property p_drop;
        @(posedge core_clk) disable iff (srst)
            wr_go && pend |=> $stable(osrs_t) && $stable(osrs_h) && $stable(gas_en) && $stable(pend_mode);
    endproperty
    a_drop: assert property (p_drop) else $error("write taken while pending");

    property p_order;
        @(posedge core_clk) disable iff (srst)
            $changed(state) && state == ESQ_HUM |-> $past(state) inside {ESQ_SLEEP, ESQ_TEMP, ESQ_PRES};
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_gas_enable;
        @(posedge core_clk) disable iff (srst) state == ESQ_HEAT |-> run_gas;
    endproperty
    a_gas_enable: assert property (p_gas_enable) else $error("gas phase without enable");

    property p_skip;
        @(posedge core_clk) disable iff (srst)
            (state == ESQ_TEMP |-> run_t != 3'h0) and (state == ESQ_PRES |-> run_p != 3'h0);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped phase ran");
endmodule
`default_nettype wire

// ---- esq_host_model.sv ----
`default_nettype none
module esq_host_model
(
    // Clock
    input  wire logic        core_clk,
    // Write side
    output var  logic [7:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // Read side
    output var  logic [7:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Address and data may be taken in either order
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        s_axi_wstrb  <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ad && wd))
        begin
            @(posedge core_clk);
            if (!ad && s_axi_awready)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready)
            begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- esq_mode_sequencer_tb.sv ----
`default_nettype none
module esq_mode_sequencer_tb import esq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HU = 4;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, heater_setpoint, sp_seen;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        conv_active, heater_on, cycle_done;
    logic        hprev = 1'b0;
    logic [31:0] cn = 0, hn = 0, dn = 0, cc = 0, pb = 0;
    int          bad_count = 0;
    int          total_checks = 0;
    int          sp[10];
    int          du[10];

    always #5 core_clk = ~core_clk;

    esq_mode_sequencer #(.HEAT_UNIT_CYCLES(HU)) i_dut (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .conv_active, .heater_on, .heater_setpoint, .cycle_done);
    esq_host_model i_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Cycle counts seen at the front end; cc restarts at each end of cycle
    always @(posedge core_clk)
    begin
        if (!srst)
        begin
            cn <= cn + conv_active;
            hn <= hn + heater_on;
            dn <= dn + cycle_done;
            cc <= cycle_done ? 32'h0 : cc + conv_active;
            hprev <= heater_on;
            if (heater_on && !hprev)
                pb <= cc;
            if (heater_on)
                sp_seen <= heater_setpoint;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic int len(input int o);
        return (o == 0) ? 0 : (ESQ_CONV_CYCLES << (o - 1));
    endfunction

    // With twice set, a write during the first cycle re-arms it and tries to move the profile
    task automatic run_one(input bit twice);
        int ot, op, oh, sel, ge, tph, h, k, c0, h0, d0;
        ot = twice ? 1 : $urandom_range(2);
        op = $urandom_range(2);
        oh = $urandom_range(2);
        sel = $urandom_range(9);
        ge = $urandom_range(1);
        k = twice ? 2 : 1;
        for (int i = 0; i < 10; i++)
        begin
            sp[i] = $urandom_range(255);
            du[i] = 1 + $urandom_range(2);
            i_host.wr(ESQ_ADDR_PROF + 8'(4 * i), 32'(du[i] * 256 + sp[i]), rs);
        end
        i_host.rd(ESQ_ADDR_PROF + 8'(4 * sel), rv, rs);
        chk(rv, du[sel] * 256 + sp[sel]);
        i_host.wr(ESQ_ADDR_HUM, 32'(oh), rs);
        i_host.wr(ESQ_ADDR_GAS, 32'(ge * 16 + sel), rs);
        i_host.wr(ESQ_ADDR_MEAS, 32'(op * 32 + ot * 4), rs);
        c0 = cn;
        h0 = hn;
        d0 = dn;
        i_host.wr(ESQ_ADDR_MEAS, 32'(op * 32 + ot * 4 + 1), rs);
        chk(rs, ESQ_RESP_OKAY);
        if (twice)
        begin
            while (!conv_active)
                @(posedge core_clk);
            i_host.wr(ESQ_ADDR_MEAS, 32'(op * 32 + ot * 4 + 1), rs);
            i_host.wr(ESQ_ADDR_GAS, 32'(16 + (sel + 1) % 10), rs);
            i_host.rd(ESQ_ADDR_STATUS, rv, rs);
            chk(rv[1:0], 2'h3);
        end
        while (dn < d0 + k)
            @(posedge core_clk);
        @(posedge core_clk);
        tph = len(ot) + len(op) + len(oh);
        // Heating counts down to zero inclusive, so it lasts one cycle beyond its units
        h = ge ? du[sel] * HU + 1 + ESQ_GAS_CYCLES : 0;
        chk(cn - c0, k * (tph + h));
        chk(hn - h0, k * h);
        chk(dn - d0, k);
        if (ge)
        begin
            chk(pb, tph);
            chk(sp_seen, sp[sel]);
        end
        chk(conv_active, 0);
        i_host.rd(ESQ_ADDR_MEAS, rv, rs);
        chk(rv, op * 32 + ot * 4);
        i_host.rd(ESQ_ADDR_GAS, rv, rs);
        chk(rv, ge * 16 + sel);
    endtask

    initial
    begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report();
    end

    initial
    begin
        void'($urandom(77));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        i_host.rd(ESQ_ADDR_MEAS, rv, rs);
        chk(rv, 0);
        chk({heater_on, conv_active}, 0);
        i_host.wr(8'h20, 32'h5, rs);
        chk(rs, ESQ_RESP_SLVERR);
        i_host.rd(8'h20, rv, rs);
        chk(rs, ESQ_RESP_SLVERR);
        $display("test reset and unmapped done");
        for (int n = 0; n < 6; n++)
        begin
            run_one(n % 3 == 2);
            $display("test cycle %0d done", n);
        end
        final_report();
    end
endmodule
`default_nettype wire
